// [include/irq_ctrl_pkg.sv]
// Constants, carrier types and lookup functions for the vectored interrupt controller.
// Assumes a single system clock domain and a 32-bit AHB-Lite register port.
package irq_ctrl_pkg;

    // Register byte offsets; only haddr[7:0] takes part in the decode.
    localparam logic [7:0] OFS_MASK_LO = 8'h00;
    localparam logic [7:0] OFS_MASK_HI = 8'h04;
    localparam logic [7:0] OFS_FORCE = 8'h08;
    localparam logic [7:0] OFS_SET_FORCE = 8'h0C;
    localparam logic [7:0] OFS_CLR_FORCE = 8'h10;
    localparam logic [7:0] OFS_REMAP_TOP = 8'h14;
    localparam logic [7:0] OFS_REMAP_SECOND = 8'h18;
    localparam logic [7:0] OFS_SW_ACK = 8'h1C;
    localparam logic [7:0] OFS_LVL1_ACK = 8'h20;
    localparam logic [7:0] OFS_LVL7_ACK = 8'h38;
    localparam logic [7:0] OFS_CORE_STATUS = 8'h3C;

    // Source numbering and vector mapping.
    localparam int NUM_SRC = 44;
    localparam int FIRST_HIGH_SRC = 39;
    localparam int FORCE_BASE = 56;
    localparam int FORCE_BITS = 7;
    localparam int FORCE_WORD_POS = 24;
    localparam logic [7:0] VEC_BASE = 8'h40;
    localparam logic [7:0] VEC_HIGH_BASE = 8'h6E;
    localparam logic [7:0] VEC_FORCE_BASE = 8'h67;
    localparam logic [7:0] VEC_SPURIOUS = 8'h18;
    localparam logic [7:0] VEC_NONE = 8'h00;
    localparam logic [5:0] SRC_NONE = 6'h3F;

    // Reset values.
    localparam logic [63:0] MASK_RESET = 64'h0000_0000_0000_0000;
    localparam logic [6:0] FORCE_RESET = 7'h00;
    localparam logic [5:0] REMAP_RESET = SRC_NONE;

    // Raw requests from the on-chip peripherals, all on sys_clk.
    typedef struct packed {
        logic lowVoltage;
        logic [3:0] dmaCh;
        logic [3:0] eventChannel;
        logic flexTimerFirstFault;
        logic flexTimerFirstOvf;
        logic [5:0] flexTimerFirstCh;
        logic flexTimerSecondFault;
        logic flexTimerSecondOvf;
        logic [5:0] flexTimerSecondCh;
        logic thirdTimerOvf;
        logic [1:0] thirdTimerCh;
        logic converter;
        logic comparatorOne;
        logic comparatorTwo;
        logic serialPeripheralOne;
        logic serialPeripheralTwo;
        logic serialPortOneErr;
        logic serialPortOneRx;
        logic serialPortOneTx;
        logic i2c;
        logic serialPortTwoErr;
        logic serialPortTwoRx;
        logic serialPortTwoTx;
        logic [4:0] keyboardGroupAE;
        logic [3:0] keyboardGroupFJ;
        logic realTimeClock;
        logic watchdogRequest;
    } periphReq_s;

    // Encoded request to the processor core.
    typedef struct packed {
        logic [2:0] level;
        logic [7:0] vector;
    } coreReq_s;

    // Vector number of a source number or forced-request bit number.
    function automatic logic [7:0] srcVector(input logic [5:0] src);
        logic [7:0] s;
        s = {2'b00, src};
        if (int'(src) >= FORCE_BASE) begin
            srcVector = VEC_FORCE_BASE + s - 8'(FORCE_BASE);
        end else if (int'(src) >= FIRST_HIGH_SRC) begin
            srcVector = VEC_HIGH_BASE + s - 8'(FIRST_HIGH_SRC);
        end else begin
            srcVector = VEC_BASE + s;
        end
    endfunction

    // Default occupant of a slot; slot 0 is priority 7, slot 4 the midpoint, slot 8 priority 0.
    function automatic logic [5:0] slotSource(input int lvl, input int slot);
        int base;
        base = 9 + 7 * (5 - lvl);
        if (slot == 8) begin
            slotSource = 6'(63 - lvl);
        end else if (lvl == 7) begin
            slotSource = (slot >= 4) ? 6'(slot - 4) : SRC_NONE;
        end else if (lvl == 6) begin
            slotSource = (slot == 2) ? 6'h04 : (slot == 3) ? 6'h05 :
                         (slot >= 5) ? 6'(slot + 1) : SRC_NONE;
        end else begin
            slotSource = (slot < 4) ? 6'(base + slot) :
                         (slot > 4) ? 6'(base + slot - 1) : SRC_NONE;
        end
    endfunction

endpackage

// [rtl/vectored_irq_unit.sv]
// Vectored priority interrupt controller with an AHB-Lite register port.
// Assumes peripheral requests are on sys_clk; the external request pin is asynchronous.
//
// Operation
// - Rank level 7 down to 1, priority 7 down to 0, midpoint between 4 and 3.
// - Sources 0 through 38 use vector 64 plus source number.
// - Sources 39 through 43 use vectors 110 through 114 in order.
// - Forced bits 56-62 request priority 0 of levels 7-1, vectors 103-109.
// - Level 7 holds pin and low voltage; level 6 holds DMA and event 0.
// - Levels 5 and 4 hold the two flex timers, combined request on top.
// - Level 3 holds third timer, converter, comparators and event channel 1.
// - Level 2 holds serial peripherals, first serial port, I2C and event 2.
// - Level 1 holds second serial port, keyboards, clock/watchdog and event 3.
// - Each flex timer's fault and overflow requests are ORed into one.
// - Keyboard requests of ports A to E are ORed into one.
// - Keyboard requests of ports F, G, I, J are ORed into one.
// - Real-time clock and watchdog requests are ORed into one.
// - A remap slot moves the written source to level 6, priority 7 or 6.
// - Both remap slots reset to a value that remaps nothing.
// - Drive a 3-bit encoded level and matching vector to the core.
// - The request mask applies to every request, level 7 included.
// - Reset restores default assignments and clears all forced bits.
// - Requests are evaluated and the outputs updated every cycle after reset.
// - Software acknowledge returns highest pending vector, masked included, else zero.
// - A level acknowledge returns the highest active vector in that level.
// - A level acknowledge with nothing active returns spurious vector 24.
`timescale 1ns/100ps
module vectored_irq_unit (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic irqPinIn,
    input wire irq_ctrl_pkg::periphReq_s periphReq,
    output irq_ctrl_pkg::coreReq_s coreReq
);
    import irq_ctrl_pkg::*;

    // Synchroniser for the external request pin.
    logic pinMeta_q;
    logic pinSync_q;

    // Bus and register state.
    logic busy_q, busy_d;
    logic write_q, write_d;
    logic [7:0] addr_q, addr_d;
    logic readyOut_q, readyOut_d;
    logic [31:0] rdata_q, rdata_d;
    logic [63:0] requestMask_q, requestMask_d;
    logic [FORCE_BITS-1:0] forcedRequestBits_q, forcedRequestBits_d;
    logic [5:0] remapSlotTop_q, remapSlotTop_d;
    logic [5:0] remapSlotSecond_q, remapSlotSecond_d;
    coreReq_s coreReq_q, coreReq_d;

    // Priority network results.
    logic [NUM_SRC-1:0] srcRaw;
    logic [63:0] reqAll;
    logic [5:0] remapTopEff;
    logic [5:0] remapSecondEff;
    logic [7:0] lvlVec [1:7];
    logic [7:0] swVec;
    logic [2:0] topLvl;
    logic [7:0] topVec;

    // Only the second stage is read by the logic.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pinMeta_q <= 1'b0;
            pinSync_q <= 1'b0;
        end else begin
            pinMeta_q <= irqPinIn;
            pinSync_q <= pinMeta_q;
        end
    end

    // Source vector indexed by source number, grouped requests combined.
    assign srcRaw = {
        periphReq.eventChannel[3],
        periphReq.realTimeClock | periphReq.watchdogRequest,
        |periphReq.keyboardGroupFJ,
        |periphReq.keyboardGroupAE,
        periphReq.serialPortTwoTx, periphReq.serialPortTwoRx, periphReq.serialPortTwoErr,
        periphReq.eventChannel[2], periphReq.i2c, periphReq.serialPortOneTx,
        periphReq.serialPortOneRx, periphReq.serialPortOneErr,
        periphReq.serialPeripheralTwo, periphReq.serialPeripheralOne,
        periphReq.eventChannel[1], periphReq.comparatorTwo, periphReq.comparatorOne,
        periphReq.converter, periphReq.thirdTimerCh, periphReq.thirdTimerOvf,
        periphReq.flexTimerSecondCh,
        periphReq.flexTimerSecondFault | periphReq.flexTimerSecondOvf,
        periphReq.flexTimerFirstCh,
        periphReq.flexTimerFirstFault | periphReq.flexTimerFirstOvf,
        periphReq.eventChannel[0], periphReq.dmaCh,
        2'b00, periphReq.lowVoltage, pinSync_q
    };

    // Only a source number that exists can be remapped.
    assign remapTopEff = (int'(remapSlotTop_q) < NUM_SRC) ? remapSlotTop_q : SRC_NONE;
    assign remapSecondEff = (int'(remapSlotSecond_q) < NUM_SRC) ? remapSlotSecond_q : SRC_NONE;

    // Levels are walked upward and slots from lowest to highest priority, so the last
    // hit seen is the winner.
    always_comb begin
        logic [5:0] id;
        logic isRemap;
        logic pend;
        logic act;
        id = SRC_NONE;
        isRemap = 1'b0;
        pend = 1'b0;
        act = 1'b0;
        reqAll = '0;
        reqAll[NUM_SRC-1:0] = srcRaw;
        reqAll[FORCE_BASE +: FORCE_BITS] = forcedRequestBits_q;
        swVec = VEC_NONE;
        topLvl = 3'h0;
        topVec = VEC_NONE;
        for (int lvl = 1; lvl <= 7; lvl++) begin
            lvlVec[lvl] = VEC_SPURIOUS;
            for (int slot = 8; slot >= 0; slot--) begin
                isRemap = (lvl == 6) && (slot < 2);
                if (isRemap) begin
                    id = (slot == 0) ? remapTopEff : remapSecondEff;
                end else begin
                    id = slotSource(lvl, slot);
                end
                pend = reqAll[id] &
                    (isRemap || (id != remapTopEff && id != remapSecondEff));
                act = pend & ~requestMask_q[id];
                if (pend) begin
                    swVec = srcVector(id);
                end
                if (act) begin
                    lvlVec[lvl] = srcVector(id);
                    topLvl = 3'(lvl);
                    topVec = srcVector(id);
                end
            end
        end
        coreReq_d.level = topLvl;
        coreReq_d.vector = topVec;
    end

    // Encoded level and vector, refreshed every cycle; the core edge-detects level 7.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            coreReq_q <= '0;
        end else begin
            coreReq_q <= coreReq_d;
        end
    end

    // Bus slave: the address phase is captured, the data phase takes one wait state in
    // which writes land and read data is registered.
    always_comb begin
        busy_d = busy_q;
        write_d = write_q;
        addr_d = addr_q;
        readyOut_d = readyOut_q;
        rdata_d = rdata_q;
        requestMask_d = requestMask_q;
        forcedRequestBits_d = forcedRequestBits_q;
        remapSlotTop_d = remapSlotTop_q;
        remapSlotSecond_d = remapSlotSecond_q;
        if (busy_q) begin
            busy_d = 1'b0;
            readyOut_d = 1'b1;
            rdata_d = 32'h0000_0000;
            if (write_q) begin
                unique case (addr_q)
                    OFS_MASK_LO: requestMask_d[31:0] = hwdata;
                    OFS_MASK_HI: requestMask_d[63:32] = hwdata;
                    OFS_FORCE: begin
                        forcedRequestBits_d = hwdata[FORCE_WORD_POS +: FORCE_BITS];
                    end
                    OFS_SET_FORCE: begin
                        if (int'(hwdata[5:0]) >= FORCE_BASE &&
                            int'(hwdata[5:0]) < FORCE_BASE + FORCE_BITS) begin
                            forcedRequestBits_d[hwdata[2:0]] = 1'b1;
                        end
                    end
                    OFS_CLR_FORCE: begin
                        if (int'(hwdata[5:0]) >= FORCE_BASE &&
                            int'(hwdata[5:0]) < FORCE_BASE + FORCE_BITS) begin
                            forcedRequestBits_d[hwdata[2:0]] = 1'b0;
                        end
                    end
                    OFS_REMAP_TOP: remapSlotTop_d = hwdata[5:0];
                    OFS_REMAP_SECOND: remapSlotSecond_d = hwdata[5:0];
                    default: begin
                    end
                endcase
            end else begin
                unique case (addr_q)
                    OFS_MASK_LO: rdata_d = requestMask_q[31:0];
                    OFS_MASK_HI: rdata_d = requestMask_q[63:32];
                    OFS_FORCE: begin
                        rdata_d[FORCE_WORD_POS +: FORCE_BITS] = forcedRequestBits_q;
                    end
                    OFS_REMAP_TOP: rdata_d[5:0] = remapSlotTop_q;
                    OFS_REMAP_SECOND: rdata_d[5:0] = remapSlotSecond_q;
                    OFS_SW_ACK: rdata_d[7:0] = swVec;
                    OFS_CORE_STATUS: rdata_d[10:0] = coreReq_q;
                    default: begin
                        if (addr_q >= OFS_LVL1_ACK && addr_q <= OFS_LVL7_ACK &&
                            addr_q[1:0] == 2'b00) begin
                            rdata_d[7:0] = lvlVec[int'(addr_q[4:2]) + 1];
                        end
                    end
                endcase
            end
        end else if (hsel && htrans[1] && hready) begin
            busy_d = 1'b1;
            write_d = hwrite;
            addr_d = haddr[7:0];
            readyOut_d = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            busy_q <= 1'b0;
            write_q <= 1'b0;
            addr_q <= 8'h00;
            readyOut_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
            requestMask_q <= MASK_RESET;
            forcedRequestBits_q <= FORCE_RESET;
            remapSlotTop_q <= REMAP_RESET;
            remapSlotSecond_q <= REMAP_RESET;
        end else begin
            busy_q <= busy_d;
            write_q <= write_d;
            addr_q <= addr_d;
            readyOut_q <= readyOut_d;
            rdata_q <= rdata_d;
            requestMask_q <= requestMask_d;
            forcedRequestBits_q <= forcedRequestBits_d;
            remapSlotTop_q <= remapSlotTop_d;
            remapSlotSecond_q <= remapSlotSecond_d;
        end
    end

    assign hrdata = rdata_q;
    assign hreadyout = readyOut_q;
    // Every transfer completes with an OKAY response.
    assign hresp = 1'b0;
    assign coreReq = coreReq_q;

endmodule

// [bench/irq_ctrl_assertions.sv]
// Concurrent checks on the ports of the vectored interrupt controller.
// Assumes one clock domain with hready tied to hreadyout.
`timescale 1ns/100ps
module irq_ctrl_checker (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic irqPinIn,
    input wire irq_ctrl_pkg::periphReq_s periphReq,
    input wire irq_ctrl_pkg::coreReq_s coreReq
);
    import irq_ctrl_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    logic start;
    assign start = hsel && htrans[1] && hready && hreadyout;
    property p_noneZero; coreReq.level == 3'h0 |-> coreReq.vector == 8'h00; endproperty
    a_noneZero: assert property (p_noneZero) else $error("idle level with a vector");
    property p_lvl7;
        coreReq.level == 3'h7 |-> coreReq.vector inside {8'h40, 8'h41, 8'h67};
    endproperty
    a_lvl7: assert property (p_lvl7) else $error("bad level 7 vector");
    property p_lvl5;
        coreReq.level == 3'h5 |-> coreReq.vector inside {[8'h49:8'h4F], 8'h69};
    endproperty
    a_lvl5: assert property (p_lvl5) else $error("bad level 5 vector");
    property p_lvl3;
        coreReq.level == 3'h3 |-> coreReq.vector inside {[8'h57:8'h5D], 8'h6B};
    endproperty
    a_lvl3: assert property (p_lvl3) else $error("bad level 3 vector");
    property p_lvl2;
        coreReq.level == 3'h2 |-> coreReq.vector inside {[8'h5E:8'h64], 8'h6C};
    endproperty
    a_lvl2: assert property (p_lvl2) else $error("bad level 2 vector");
    property p_lvl1;
        coreReq.level == 3'h1 |-> coreReq.vector inside {8'h65, 8'h66, [8'h6D:8'h72]};
    endproperty
    a_lvl1: assert property (p_lvl1) else $error("bad level 1 vector");
    property p_wait; start |=> !hreadyout ##1 hreadyout; endproperty
    a_wait: assert property (p_wait) else $error("transfer not one wait state");
    property p_okay; hresp == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("response not okay");
    property p_lvlAck;
        start && !hwrite && haddr[7:0] inside {[8'h20:8'h38]} |=> ##1 hrdata[7:0] != 8'h00;
    endproperty
    a_lvlAck: assert property (p_lvlAck) else $error("level acknowledge returned zero");
    property p_swAck;
        start && !hwrite && haddr[7:0] == 8'h1C ##2 coreReq.level != 3'h0 |-> hrdata[7:0] != 8'h00;
    endproperty
    a_swAck: assert property (p_swAck) else $error("software acknowledge missed a request");
    property p_steady;
        (!hsel && $stable(periphReq) && $stable(irqPinIn)) [*5] |=> $stable(coreReq);
    endproperty
    a_steady: assert property (p_steady) else $error("core request moved by itself");
    c_lvl7: cover property (coreReq.level == 3'h7);
    c_remap: cover property (coreReq == {3'h6, 8'h61});
    c_spur: cover property (start && !hwrite && haddr[7:0] == 8'h24);
endmodule
bind vectored_irq_unit irq_ctrl_checker chk_u (.sys_clk, .nrst, .hsel, .haddr, .htrans, .hwrite,
    .hready, .hrdata, .hreadyout, .hresp, .irqPinIn, .periphReq, .coreReq);

// [bench/core_model.sv]
// Behavioural processor core counting non-maskable interrupts seen on the encoded level.
// Assumes coreReq is registered on sys_clk and the mask level comes from the bench.
`timescale 1ns/100ps
module core_model (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire irq_ctrl_pkg::coreReq_s coreReq,
    input wire logic [2:0] coreMaskLevel,
    output logic [7:0] nmiCount_q
);
    import irq_ctrl_pkg::*;
    logic [2:0] lastLvl_q, lastMask_q;
    logic [7:0] nmiCount_d;
    logic nmiEvent;
    // Level seven is taken on its edge, or when the mask drops while it stands.
    assign nmiEvent = coreReq.level == 3'h7 &&
        (lastLvl_q != 3'h7 || (lastMask_q == 3'h7 && coreMaskLevel != 3'h7));
    always_comb begin
        nmiCount_d = nmiCount_q + {7'h00, nmiEvent};
    end
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            lastLvl_q <= 3'h0;
            lastMask_q <= 3'h0;
            nmiCount_q <= 8'h00;
        end else begin
            lastLvl_q <= coreReq.level;
            lastMask_q <= coreMaskLevel;
            nmiCount_q <= nmiCount_d;
        end
    end
endmodule

// [bench/testbench.sv]
// Self-checking bench: a table of single requests, then ranking, masking, force and remap tests.
// Assumes one wait state per bus transfer and coreReq one edge behind its inputs.
`timescale 1ns/100ps
module testbench;
    import irq_ctrl_pkg::*;
    typedef struct {int idx; logic [2:0] lvl; logic [7:0] vec;} row_s;
    logic sys_clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0, irqPinIn = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2, coreMaskLevel = 3'h7;
    logic hreadyout, hresp;
    logic [7:0] nmiCount_q;
    logic [$bits(periphReq_s)-1:0] one = {{($bits(periphReq_s)-1){1'b0}}, 1'b1};
    periphReq_s periphReq = '0;
    coreReq_s coreReq;
    int n_errors = 0, checked = 0, cyc = 0;
    row_s rows[$] = '{'{50, 7, 8'h41}, '{46, 6, 8'h44}, '{49, 6, 8'h47}, '{42, 6, 8'h48},
        '{41, 5, 8'h49}, '{40, 5, 8'h49}, '{34, 5, 8'h4A}, '{39, 5, 8'h4F}, '{33, 4, 8'h50},
        '{32, 4, 8'h50}, '{31, 4, 8'h56}, '{25, 3, 8'h57}, '{24, 3, 8'h59}, '{22, 3, 8'h5A},
        '{21, 3, 8'h5B}, '{20, 3, 8'h5C}, '{43, 3, 8'h5D}, '{19, 2, 8'h5E}, '{16, 2, 8'h61},
        '{14, 2, 8'h63}, '{44, 2, 8'h64}, '{13, 1, 8'h65}, '{12, 1, 8'h66}, '{11, 1, 8'h6E},
        '{6, 1, 8'h6F}, '{10, 1, 8'h6F}, '{2, 1, 8'h70}, '{5, 1, 8'h70}, '{1, 1, 8'h71},
        '{0, 1, 8'h71}, '{45, 1, 8'h72}};
    vectored_irq_unit dut_u (.sys_clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .irqPinIn, .periphReq, .coreReq);
    core_model core_u (.sys_clk, .nrst, .coreReq, .coreMaskLevel, .nmiCount_q);
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic close_out();
        $display("checked %0d, errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            n_errors++;
            $display("Error %0t: timeout", $time);
            close_out();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic cmpWord(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %0t: read %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic cmpCore(input logic [2:0] l, input logic [7:0] v);
        checked++;
        if (coreReq !== {l, v}) begin
            n_errors++;
            $display("Error %0t: core %h, expected %h", $time, coreReq, {l, v});
        end
    endtask
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        tick(1);
        while (hreadyout !== 1'b1) tick(1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        tick(1);
        while (hreadyout !== 1'b1) tick(1);
        rd = hrdata;
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        cmpWord(rd, exp);
    endtask
    initial begin
        tick(5);
        nrst <= 1'b1;
        tick(1);
        cmpCore(3'h0, 8'h00);
        rdChk(OFS_REMAP_TOP, 32'h3F);
        rdChk(OFS_REMAP_SECOND, 32'h3F);
        rdChk(OFS_FORCE, 32'h0);
        rdChk(OFS_SW_ACK, 32'h0);
        rdChk(OFS_LVL1_ACK, 32'h18);
        rdChk(8'h40, 32'h0);
        $display("test reset done");
        foreach (rows[i]) begin
            periphReq <= periphReq_s'(one << rows[i].idx);
            tick(2);
            cmpCore(rows[i].lvl, rows[i].vec);
            rdChk(OFS_SW_ACK, {24'h0, rows[i].vec});
            rdChk(8'h1C + {3'h0, rows[i].lvl, 2'h0}, {24'h0, rows[i].vec});
            periphReq <= '0;
            tick(1);
        end
        $display("test table done");
        periphReq.lowVoltage <= 1'b1;
        periphReq.converter <= 1'b1;
        periphReq.comparatorOne <= 1'b1;
        periphReq.serialPortOneRx <= 1'b1;
        tick(2);
        cmpCore(3'h7, 8'h41);
        irqPinIn <= 1'b1;
        tick(4);
        cmpCore(3'h7, 8'h40);
        cmpWord({24'h0, nmiCount_q}, 32'h2);
        rdChk(8'h28, 32'h5A);
        coreMaskLevel <= 3'h0;
        tick(2);
        cmpWord({24'h0, nmiCount_q}, 32'h3);
        xfer(OFS_MASK_LO, 1'b1, 32'h3);
        tick(1);
        cmpCore(3'h3, 8'h5A);
        rdChk(OFS_SW_ACK, 32'h40);
        xfer(OFS_MASK_LO, 1'b1, 32'h0);
        periphReq <= '0;
        irqPinIn <= 1'b0;
        tick(4);
        $display("test ranking done");
        for (int s = 56; s <= 62; s++) begin
            xfer(OFS_SET_FORCE, 1'b1, 32'(s));
            tick(1);
            cmpCore(3'(63 - s), 8'(47 + s));
            xfer(OFS_CLR_FORCE, 1'b1, 32'(s));
        end
        xfer(OFS_MASK_HI, 1'b1, 32'h0100_0000);
        rdChk(OFS_MASK_HI, 32'h0100_0000);
        xfer(OFS_SET_FORCE, 1'b1, 32'h38);
        tick(1);
        cmpCore(3'h0, 8'h00);
        rdChk(OFS_SW_ACK, 32'h67);
        $display("test force done");
        xfer(OFS_REMAP_TOP, 1'b1, 32'h21);
        xfer(OFS_REMAP_SECOND, 1'b1, 32'h22);
        periphReq.serialPortOneRx <= 1'b1;
        periphReq.serialPortOneTx <= 1'b1;
        periphReq.dmaCh <= 4'h1;
        tick(2);
        cmpCore(3'h6, 8'h61);
        rdChk(8'h24, 32'h18);
        periphReq.serialPortOneRx <= 1'b0;
        tick(2);
        cmpCore(3'h6, 8'h62);
        rdChk(OFS_CORE_STATUS, 32'h662);
        rdChk(8'h34, 32'h62);
        nrst <= 1'b0;
        tick(2);
        nrst <= 1'b1;
        tick(2);
        cmpCore(3'h6, 8'h44);
        rdChk(OFS_REMAP_TOP, 32'h3F);
        rdChk(OFS_FORCE, 32'h0);
        rdChk(8'h24, 32'h62);
        $display("test remap done");
        close_out();
    end
endmodule
